// file: octsw_pkg.sv
// Constants shared by the octal switch serial control block
package octsw_pkg;
  // Channel counts
  localparam int NUM_CH = 8;
  localparam int PAR_CH = 4;
  // Frame layout, most significant bit first
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] CNT_SAT = 5'h11;
  localparam logic [3:0] SO_LAST = 4'hf;
  localparam int CTRL_MSB = 15;
  localparam int CTRL_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam logic [7:0] CTRL_DIAG_ONLY = 8'h00;
  // Two-bit diagnostic codes
  localparam logic [1:0] DIAG_NORMAL = 2'h3;
  localparam logic [1:0] DIAG_OVERLOAD = 2'h2;
  localparam logic [1:0] DIAG_OPEN = 2'h1;
  localparam logic [1:0] DIAG_SHORT_GND = 2'h0;
  localparam logic [15:0] DIAG_ALL_NORMAL = 16'hffff;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int THERM_PERIOD_US = 1000;
  localparam int THERM_DUTY_DIV = 8;
  // Packing of the pin synchroniser word
  localparam int SY_OTP = 0;
  localparam int SY_SGD = 8;
  localparam int SY_OPN = 16;
  localparam int SY_OVL = 24;
  localparam int SY_PAR = 32;
  localparam int SY_POL = 36;
  localparam int SYNC_W = 37;
endpackage : octsw_pkg

// file: octsw_link_if.sv
// Carrier between the core domain and the serial link logic
`timescale 1ns/10ps
interface octsw_link_if;
  import octsw_pkg::*;
  logic clr;
  logic [FRAME_BITS-1:0] snap;
  logic [FRAME_BITS-1:0] rx;
  logic [4:0] rx_cnt;
  modport core (output clr, output snap, input rx, input rx_cnt);
  modport link (input clr, input snap, output rx, output rx_cnt);
endinterface : octsw_link_if

// file: octsw_link.sv
// Serial shift logic clocked by the host serial clock
`timescale 1ns/10ps
module octsw_link
  import octsw_pkg::*;
(
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe_n,
  // Core side
  octsw_link_if.link lk
);

  logic [FRAME_BITS-1:0] shreg;
  logic [4:0] fcnt;
  logic [3:0] rcnt;

  // Shift in on falling edge; clr is a core flop, so it cannot glitch
  always_ff @(negedge sclk or posedge lk.clr)
  begin
    if (lk.clr)
    begin
      shreg <= '0;
      fcnt <= '0;
    end
    else if (!cs_n)
    begin
      shreg <= {shreg[FRAME_BITS-2:0], si};
      if (fcnt != CNT_SAT)
      begin
        fcnt <= fcnt + 5'h01;
      end
    end
  end

  // Output bit index advances on the rising edge
  always_ff @(posedge sclk or posedge lk.clr)
  begin
    if (lk.clr)
    begin
      rcnt <= '0;
    end
    else if (!cs_n && rcnt != SO_LAST)
    begin
      rcnt <= rcnt + 4'h1;
    end
  end

  // Snapshot is static for the whole frame, so the mux is safe
  assign so_out = lk.snap[SO_LAST - rcnt];
  assign so_oe_n = cs_n;
  assign lk.rx = shreg;
  assign lk.rx_cnt = fcnt;

endmodule : octsw_link

// file: octsw_diag.sv
// Per-channel latched diagnosis codes
`timescale 1ns/10ps
module octsw_diag
  import octsw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Clear at end of frame
  input wire logic clr,
  // Synchronised fault flags
  input wire logic [NUM_CH-1:0] overload,
  input wire logic [NUM_CH-1:0] overtemp,
  input wire logic [NUM_CH-1:0] open_load,
  input wire logic [NUM_CH-1:0] short_gnd,
  // Latched codes, channel 8 in the top pair
  output logic [2*NUM_CH-1:0] code,
  output logic event_any
);

  logic [NUM_CH-1:0] hit;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic [1:0] ev;
      // Overload outranks open load, open load outranks short to ground
      assign ev = (overload[ch] | overtemp[ch]) ? DIAG_OVERLOAD :
                  open_load[ch] ? DIAG_OPEN :
                  short_gnd[ch] ? DIAG_SHORT_GND : DIAG_NORMAL;
      assign hit[ch] = overload[ch] | overtemp[ch] | open_load[ch] |
                       short_gnd[ch];
      // A fresh event beats the clear so it is never lost
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          code[2*ch+1:2*ch] <= DIAG_NORMAL;
        end
        else if (hit[ch])
        begin
          code[2*ch+1:2*ch] <= ev;
        end
        else if (clr)
        begin
          code[2*ch+1:2*ch] <= DIAG_NORMAL;
        end
      end
    end
  endgenerate

  assign event_any = |hit;

endmodule : octsw_diag

// file: octsw_top.sv
// Serial and parallel control core of an eight-channel low-side switch
//
// Notes on behaviour
// - Sample serial input on falling serial clock
// - Data bit one on, zero off
// - Chip select rise copies frame to latches
// - Own latch per channel, reset clears all
// - Channels 1-4 need parallel and serial on
// - Polarity pin selects parallel input sense
// - Unconnected parallel inputs keep channels off
// - Overload sets overload code early
// - Overtemperature gives low duty restarting pattern
// - Chip select fall loads diagnosis snapshot
// - Chip select fall starts driving serial out
// - Chip select rise clears diagnosis latches
// - Chip select high ignores clock, floats output
// - Diagnosis bits advance on rising serial clock
// - Accept only frames of exactly sixteen clocks
// - Input bits arrive most significant first
// - Frame is control byte then data byte
// - Output bits leave most significant first
// - Control byte zero means diagnosis only
// - Codes 11 normal, 10 overload, 01, 00
// - Reset clears shift register, outputs off
// - Fault output low on any latched error
`timescale 1ns/10ps
module octsw_top
  import octsw_pkg::*;
#(
  parameter int THERM_PERIOD_CYC = THERM_PERIOD_US * 1000 / CLK_PERIOD_NS
)
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe_n,
  // Parallel control
  input wire logic input_polarity_select,
  input wire logic [PAR_CH-1:0] parallel_drive,
  // Fault flags from the output stages
  input wire logic [NUM_CH-1:0] overload,
  input wire logic [NUM_CH-1:0] overtemp,
  input wire logic [NUM_CH-1:0] open_load,
  input wire logic [NUM_CH-1:0] short_gnd,
  // Power stage gates
  output logic [NUM_CH-1:0] power_switch,
  // Open-drain general fault pin
  output logic fault_out,
  output logic fault_oe_n
);

  localparam int THERM_ON_CYC = THERM_PERIOD_CYC / THERM_DUTY_DIV;

  octsw_link_if lk ();

  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic cs_a;
  logic cs_b;
  logic cs_d;
  logic [NUM_CH-1:0] out_latch;
  logic [2*NUM_CH-1:0] diag_code;
  logic [31:0] pwm_cnt;
  logic any_fault;
  logic event_any;

  wire logic cs_fall;
  wire logic cs_rise;
  wire logic frame_ok;
  wire logic [7:0] rx_ctrl;
  wire logic [7:0] rx_data;
  wire logic pol;
  wire logic [PAR_CH-1:0] par_act;
  wire logic [NUM_CH-1:0] par_mask;
  wire logic [NUM_CH-1:0] otp_s;
  wire logic [NUM_CH-1:0] therm_mask;
  wire logic pwm_on;

  // Serial link logic on its own clock
  octsw_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .si(si),
    .so_out(so_out),
    .so_oe_n(so_oe_n),
    .lk(lk.link)
  );

  // Two-stage synchroniser for the polarity, parallel and fault flag pins
  always_ff @(posedge clk)
  begin
    sync_a <= {input_polarity_select, parallel_drive, overload, open_load,
               short_gnd, overtemp};
    sync_b <= sync_a;
  end

  // Chip select crossing and edge history
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cs_a <= 1'h1;
      cs_b <= 1'h1;
      cs_d <= 1'h1;
    end
    else
    begin
      cs_a <= cs_n;
      cs_b <= cs_a;
      cs_d <= cs_b;
    end
  end

  // Frame decode; link words are still once chip select has risen
  assign cs_fall = cs_d & ~cs_b;
  assign cs_rise = ~cs_d & cs_b;
  assign rx_ctrl = lk.rx[CTRL_MSB:CTRL_LSB];
  assign rx_data = lk.rx[DATA_MSB:DATA_LSB];
  assign frame_ok = (lk.rx_cnt == FRAME_LEN);

  // Output latches, updated only by a complete control frame
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_latch <= '0;
    end
    else if (cs_rise && frame_ok && rx_ctrl != CTRL_DIAG_ONLY)
    begin
      out_latch <= rx_data;
    end
  end

  // Link clear: held from frame end to next frame start, so the link
  // counters restart at zero without needing a serial clock edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lk.clr <= 1'h1;
    end
    else if (cs_rise)
    begin
      lk.clr <= 1'h1;
    end
    else if (cs_fall)
    begin
      lk.clr <= 1'h0;
    end
  end

  // Diagnosis snapshot held static while the frame shifts out
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lk.snap <= DIAG_ALL_NORMAL;
    end
    else if (cs_fall)
    begin
      lk.snap <= diag_code;
    end
  end

  // Latched diagnosis, cleared at frame end except where a fresh event arrives in that cycle
  octsw_diag u_diag (
    .clk(clk),
    .rst_n(rst_n),
    .clr(cs_rise),
    .overload(sync_b[SY_OVL +: NUM_CH]),
    .overtemp(otp_s),
    .open_load(sync_b[SY_OPN +: NUM_CH]),
    .short_gnd(sync_b[SY_SGD +: NUM_CH]),
    .code(diag_code),
    .event_any(event_any)
  );

  // Parallel inputs; pins idle at the inactive level when left open
  assign pol = sync_b[SY_POL];
  assign par_act = pol ? sync_b[SY_PAR +: PAR_CH] :
                   ~sync_b[SY_PAR +: PAR_CH];
  assign par_mask = {{(NUM_CH-PAR_CH){1'h1}}, par_act};

  // Shared restart timer; one counter keeps all hot channels in step
  always_ff @(posedge clk)
  begin
    if (!rst_n || pwm_cnt == 32'(THERM_PERIOD_CYC - 1))
    begin
      pwm_cnt <= '0;
    end
    else
    begin
      pwm_cnt <= pwm_cnt + 32'h1;
    end
  end

  assign pwm_on = (pwm_cnt < 32'(THERM_ON_CYC));
  assign otp_s = sync_b[SY_OTP +: NUM_CH];
  assign therm_mask = pwm_on ? {NUM_CH{1'h1}} : ~otp_s;

  // Gate drive registered so the pins never glitch
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      power_switch <= '0;
    end
    else
    begin
      power_switch <= out_latch & par_mask & therm_mask;
    end
  end

  // Fault pin pulls low while any code is latched
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      any_fault <= 1'h0;
    end
    else
    begin
      any_fault <= (diag_code != DIAG_ALL_NORMAL);
    end
  end

  assign fault_out = 1'h0;
  assign fault_oe_n = ~any_fault;

  // Checks on the core domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence good_end_s;
    cs_rise && frame_ok && rx_ctrl != CTRL_DIAG_ONLY;
  endsequence

  sequence skip_end_s;
    cs_rise && (!frame_ok || rx_ctrl == CTRL_DIAG_ONLY);
  endsequence

  property latch_load_p;
    good_end_s |=> out_latch == $past(rx_data);
  endproperty

  property latch_hold_p;
    skip_end_s |=> $stable(out_latch);
  endproperty

  latch_load_a: assert property (latch_load_p)
    else $error("output latches not loaded at frame end");

  frame_count_a: assert property (cs_rise && !frame_ok |=>
    $stable(out_latch))
    else $error("short or long frame changed the latches");

  diag_only_a: assert property (latch_hold_p)
    else $error("diagnosis-only frame changed the latches");

  parallel_and_a: assert property ($past(out_latch[3:0] & par_act) ==
    4'h0 |-> power_switch[3:0] == 4'h0)
    else $error("parallel channel on without both enables");

  off_bit_a: assert property ((power_switch & ~$past(out_latch)) ==
    8'h00)
    else $error("channel on while its data bit is zero");

  // Must stay live during reset, so the default disable is overridden
  reset_off_a: assert property (@(posedge clk) disable iff (1'b0)
    !rst_n |=> power_switch == 8'h00 && out_latch == 8'h00 && lk.clr)
    else $error("reset did not switch every channel off");

  snap_load_a: assert property (cs_fall |=>
    lk.snap == $past(diag_code) ##1 $stable(lk.snap))
    else $error("snapshot not taken at chip select fall");

  diag_clear_a: assert property (cs_rise && !event_any |=>
    diag_code == DIAG_ALL_NORMAL)
    else $error("diagnosis not cleared at frame end");

  thermal_duty_a: assert property ((power_switch & $past(otp_s)) !=
    8'h00 |-> $past(pwm_on))
    else $error("hot channel driven outside its on window");

  fault_pin_a: assert property (event_any |-> ##2 !fault_oe_n)
    else $error("fault pin not pulled low after an event");

  link_clear_a: assert property (cs_rise |=> lk.clr [*2])
    else $error("link counters not cleared after frame end");

endmodule : octsw_top

// file: octsw_host.sv
// Host serial master model that drives frames into the switch
`timescale 1ns/10ps
module octsw_host (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe_n
);
  // Idle levels: clock low, deselected, data at its pull-down
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // One frame of n pulses at 160 ns; SO read just before each rise,
  // since the link shows the top bit from chip select fall onwards
  task xfer(input logic [15:0] tx, input int n,
            output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #300;
    for (int i = 0; i < n; i++)
    begin
      si = tx[15 - (i % 16)];
      // A floating SO must not read as a good bit
      #20 rx = {rx[14:0], so_oe_n ? ~rx[0] : so_out};
      #20 sclk = 1'b1;
      #80 sclk = 1'b0;
      #40;
    end
    #250 cs_n = 1'b1;
    si = 1'b0;
    #300;
  endtask : xfer
endmodule : octsw_host

// file: octal_switch_serial_control_tb_top.sv
// Self-checking bench for the octal switch serial control core
`timescale 1ns/10ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", nm, e, a); end end
module octal_switch_serial_control_tb_top
  import octsw_pkg::*;
;
  // Short thermal period keeps the duty check quick
  localparam int TP = 64;
  logic clk, rst_n, sclk, cs_n, si, so_out, so_oe_n, pol;
  logic fault_out, fault_oe_n;
  logic [3:0] par;
  logic [7:0] ovl, otp, opn, sgd, power_switch;
  logic [15:0] rx;
  int miscompares = 0;
  int total_checks = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  octsw_top #(.THERM_PERIOD_CYC(TP)) u_octsw_top (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe_n(so_oe_n),
    .input_polarity_select(pol), .parallel_drive(par),
    .overload(ovl), .overtemp(otp), .open_load(opn), .short_gnd(sgd),
    .power_switch(power_switch), .fault_out(fault_out),
    .fault_oe_n(fault_oe_n));

  octsw_host u_octsw_host (.sclk(sclk), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe_n(so_oe_n));

  task test_done;
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Outputs off and SO floating while held in reset
  task t_reset;
    `CHK("power", 8'h00, power_switch)
    `CHK("so_oe", 1'b1, so_oe_n)
    `CHK("fault", 1'b1, fault_oe_n)
    `CHK("fault_d", 1'b0, fault_out)
  endtask : t_reset

  // Writes, including a non-zero but odd control byte
  task t_write;
    u_octsw_host.xfer(16'hffa5, 16, rx);
    `CHK("diag", 16'hffff, rx)
    `CHK("power", 8'ha5, power_switch)
    u_octsw_host.xfer(16'h015a, 16, rx);
    `CHK("power", 8'h5a, power_switch)
  endtask : t_write

  // Diagnosis-only and miscounted frames change nothing
  task t_refuse;
    u_octsw_host.xfer(16'h00a5, 16, rx);
    `CHK("power", 8'h5a, power_switch)
    u_octsw_host.xfer(16'hffa5, 15, rx);
    `CHK("power", 8'h5a, power_switch)
    u_octsw_host.xfer(16'hffa5, 17, rx);
    `CHK("power", 8'h5a, power_switch)
  endtask : t_refuse

  // Both polarities, inactive pins included, against serial ones
  task t_par;
    logic [3:0] want;
    u_octsw_host.xfer(16'hffff, 16, rx);
    for (int p = 0; p < 2; p++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        @(posedge clk);
        pol <= p[0];
        par <= 4'(k * 5);
        repeat (20) @(posedge clk);
        want = p[0] ? par : ~par;
        `CHK("par", {4'hf, want}, power_switch)
      end
    end
  endtask : t_par

  // Faults latch until a frame ends, channel 8 pair first
  task t_diag;
    @(posedge clk);
    ovl <= 8'h80;
    opn <= 8'h01;
    sgd <= 8'h02;
    repeat (10) @(posedge clk);
    `CHK("fault", 1'b0, fault_oe_n)
    ovl <= 8'h00;
    opn <= 8'h00;
    sgd <= 8'h00;
    repeat (10) @(posedge clk);
    u_octsw_host.xfer(16'h0000, 16, rx);
    `CHK("diag", 16'hbff1, rx)
    u_octsw_host.xfer(16'h0000, 16, rx);
    `CHK("diag", 16'hffff, rx)
    `CHK("fault", 1'b1, fault_oe_n)
  endtask : t_diag

  // Hot channel runs at one eighth duty over two periods
  task t_therm;
    int n;
    n = 0;
    @(posedge clk);
    otp <= 8'h10;
    repeat (20) @(posedge clk);
    repeat (2 * TP)
    begin
      // Sample away from the edge that launches the output
      @(negedge clk);
      n += int'(power_switch[4]);
    end
    `CHK("duty", 2 * TP / 8, n)
  endtask : t_therm

  // Mid-run reset switches every channel off and frees the fault pin;
  // faults are dropped first so no event meets the release
  task t_rerst;
    @(posedge clk);
    rst_n <= 1'b0;
    otp <= 8'h00;
    repeat (4) @(posedge clk);
    `CHK("power", 8'h00, power_switch)
    `CHK("fault", 1'b1, fault_oe_n)
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("power", 8'h00, power_switch)
  endtask : t_rerst

  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    pol = 1'b1;
    par = 4'hf;
    ovl = 8'h00;
    otp = 8'h00;
    opn = 8'h00;
    sgd = 8'h00;
    repeat (16) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_write();
    t_refuse();
    t_par();
    t_diag();
    t_therm();
    t_rerst();
    test_done();
  end

  // Watchdog well past the roughly 30 us of traffic
  initial
  begin
    #300000;
    miscompares++;
    test_done();
  end
endmodule : octal_switch_serial_control_tb_top
